// ===== hw/flash_status_register.sv
// Purpose: Flash control and status register with Avalon-MM access.
// Assumes: Sequencer, protection status and write requests on clk_sys;
//          the ROM kind strap is a pin and is synchronised.
// Notes:   One wait state per access; interrupt bits are write one to clear.
//
// Behaviour
// R1 - Busy operation reads ready flag as zero.
// R2 - Normal completion returns ready flag to one.
// R3 - Failed operation keeps ready flag at zero.
// R4 - Hardware reset forces ready flag back to one.
// R5 - Bit two: zero flash, one mask ROM.
// R6 - Bits seven to four report block protection.
// R7 - Protected block refuses every data write.
// R8 - Software checks ready before issuing commands.
// R9 - Busy-time commands dropped; reset command recovers.
// R10 - All protected: block outside reads, commands.
// R11 - Other bits zero, writes ignored, reset 0x1.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module flash_status_register (
   input  wire logic                       clk_sys,
   input  wire logic                       sys_rst,
   input  wire flash_status_pkg::avm_req_s avm,
   output logic [31:0]                     avm_readdata_q,
   output logic                            avm_waitrequest_q,
   input  wire flash_status_pkg::op_evt_s  op_evt,
   input  wire logic                       rom_mask_strap,
   input  wire logic [3:0]                 prot_status,
   input  wire logic                       wr_req,
   input  wire logic [1:0]                 wr_block,
   input  wire logic                       cmd_req,
   output logic                            wr_grant_q,
   output logic                            wr_refuse_q,
   output logic                            cmd_accept_q,
   output logic                            cmd_drop_q,
   output logic                            ext_rd_block_q,
   output logic                            ready_q,
   output logic                            irq_q
);
   import flash_status_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Declarations.

   logic              trk_ready;      // Ready flag from the tracker.

   logic              rom_s1_q;       // First strap synchroniser stage.
   logic              rom_s2_q;       // Second strap synchroniser stage.
   logic              rom_kind_q;     // Frozen ROM kind.
   logic [1:0]        strap_cnt_q;    // Cycles since reset release.

   logic [IRQ_W-1:0]  stat_q;         // Sticky interrupt status.
   logic [IRQ_W-1:0]  stat_d;         // Next interrupt status.
   logic [IRQ_W-1:0]  mask_q;         // Interrupt mask.
   logic [IRQ_W-1:0]  mask_d;         // Next interrupt mask.
   logic [IRQ_W-1:0]  evt_set;        // Events raised this cycle.
   logic [IRQ_W-1:0]  w1c_clr;        // Bits software clears now.

   logic [31:0]       fcs_val;        // Live status word.
   logic [31:0]       rd_mux;         // Selected read value.
   logic              hit_fcs;        // Address hits status word.
   logic              hit_stat;       // Address hits interrupt status.
   logic              hit_mask;       // Address hits interrupt mask.
   logic              wr_take;        // Write completes at this edge.
   logic              rd_load;        // Read data loads at this edge.

   logic              all_locked;     // Every block is protected.
   logic              prot_hit;       // Requested block is protected.
   logic              cmd_ok;         // A command may pass now.
   logic              op_busy;        // Automatic operation running or stuck after failure.

   ////////////////////////////////////////////////////////////////////
   // Operation tracking.

   // The tracker owns the ready, busy and failed sequence.
   flash_op_tracker u_tracker (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .evt     (op_evt),
      .ready_q (trk_ready)
   );

   // Busy covers both a running and a stuck operation.
   assign op_busy = ~trk_ready;                          // [R1] [R3]

   ////////////////////////////////////////////////////////////////////
   // ROM kind strap.

   // Two flops bring the strap pin into the clock domain.
   // Only the second stage is read, so a metastable first stage settles.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rom_s1_q <= 1'b0;
         rom_s2_q <= 1'b0;
      end else begin
         rom_s1_q <= rom_mask_strap;
         rom_s2_q <= rom_s1_q;
      end
   end

   // The strap is followed for a few cycles after reset, then frozen.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         strap_cnt_q <= STRAP_RST;
         rom_kind_q  <= 1'b0;
      end else if (strap_cnt_q != STRAP_WAIT) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
         rom_kind_q  <= rom_s2_q;                         // [R5]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status word.

   // Every block protected means the flash is sealed.
   assign all_locked = (prot_status == PROT_ALL);        // [R10]

   // Unused bits stay zero; only the named fields are filled in.
   always_comb begin
      fcs_val                          = 32'h0000_0000;  // [R11]
      fcs_val[RDY_BIT]                 = trk_ready;      // [R1] [R2]
      fcs_val[ROM_BIT]                 = rom_kind_q;     // [R5]
      fcs_val[PROT_LSB+:PROT_W]        = prot_status;    // [R6]
   end

   ////////////////////////////////////////////////////////////////////
   // Avalon-MM slave decode.

   // Full byte-address compare for each register.
   assign hit_fcs  = (avm.address == FCS_OFS);
   assign hit_stat = (avm.address == IRQ_STAT_OFS);
   assign hit_mask = (avm.address == IRQ_MASK_OFS);

   // Reads load while waitrequest is high; writes land while it is low.
   assign rd_load = avm.read & avm_waitrequest_q;
   assign wr_take = avm.write & ~avm_waitrequest_q;

   // Unmapped addresses read as zero.
   assign rd_mux = hit_fcs  ? fcs_val :
                   hit_stat ? {28'h0000000, stat_q} :
                   hit_mask ? {28'h0000000, mask_q} :
                   32'h0000_0000;

   // Waitrequest drops for one cycle, one cycle after a request.
   // Idle high keeps a request waiting until it has been registered.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         avm_waitrequest_q <= 1'b1;
      end else begin
         avm_waitrequest_q <= ~((avm.read | avm.write)
                                & avm_waitrequest_q);
      end
   end

   // Read data is captured at the edge that drops waitrequest.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         avm_readdata_q <= 32'h0000_0000;
      end else if (rd_load) begin
         avm_readdata_q <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Write and command gating.

   // A write into a protected block is refused.
   assign prot_hit = prot_status[wr_block];              // [R7]

   // Commands pass only when ready and the flash is not sealed.
   assign cmd_ok = trk_ready & ~all_locked;              // [R9] [R10]

   // Grant, refuse, accept and drop are one-cycle pulses toward the sequencer.
   // Protection is judged in the request cycle itself.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_grant_q     <= 1'b0;
         wr_refuse_q    <= 1'b0;
         cmd_accept_q   <= 1'b0;
         cmd_drop_q     <= 1'b0;
         ext_rd_block_q <= 1'b0;
         ready_q        <= 1'b1;                          // [R4]
      end else begin
         wr_grant_q     <= wr_req & ~prot_hit;            // [R7]
         wr_refuse_q    <= wr_req & prot_hit;             // [R7]
         cmd_accept_q   <= cmd_req & cmd_ok;              // [R9]
         cmd_drop_q     <= cmd_req & ~cmd_ok;             // [R9]
         ext_rd_block_q <= all_locked;                    // [R10]
         ready_q        <= trk_ready;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupts.

   // Events: completion, failure, refused write, dropped command.
   assign evt_set[IRQ_DONE] = op_evt.done & op_busy & ~op_evt.fail;
   assign evt_set[IRQ_FAIL] = op_evt.fail & op_busy;
   assign evt_set[IRQ_WREF] = wr_req & prot_hit;
   assign evt_set[IRQ_DROP] = cmd_req & ~cmd_ok;

   // Write one to clear, honouring byte lane zero.
   assign w1c_clr = (wr_take & hit_stat & avm.byteenable[0])
                    ? avm.writedata[IRQ_W-1:0] : IRQ_RST;

   // A new event wins over a clear in the same cycle.
   assign stat_d = (stat_q & ~w1c_clr) | evt_set;

   // The mask takes byte lane zero of a write.
   assign mask_d = (wr_take & hit_mask & avm.byteenable[0])
                   ? avm.writedata[IRQ_W-1:0] : mask_q;

   // Status, mask and the level interrupt output.
   // The interrupt flop trails a status change by one cycle.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         stat_q <= IRQ_RST;
         mask_q <= IRQ_RST;
         irq_q  <= 1'b0;
      end else begin
         stat_q <= stat_d;
         mask_q <= mask_d;
         irq_q  <= |(stat_q & mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // Ready bit in read data follows the tracker.
   chk_ready_readback: // [R1]
      assert property (rd_load && hit_fcs |=>
                       avm_readdata_q[RDY_BIT] == $past(trk_ready))
      else $error("ready bit read back wrong");

   // ROM kind bit reads the frozen strap.
   chk_rom_kind_bit: // [R5]
      assert property (rd_load && hit_fcs |=>
                       avm_readdata_q[ROM_BIT] == $past(rom_kind_q))
      else $error("rom kind bit read back wrong");

   // Strap stays frozen once captured.
   chk_strap_frozen: // [R5]
      assert property (strap_cnt_q == STRAP_WAIT |=> $stable(rom_kind_q))
      else $error("rom kind changed after capture");

   // Protection field mirrors the block status.
   chk_protect_field: // [R6]
      assert property (rd_load && hit_fcs |=>
                       avm_readdata_q[7:4] == $past(prot_status))
      else $error("protection field read back wrong");

   // Writes to protected blocks are refused, never granted.
   chk_write_refused: // [R7]
      assert property (wr_req && prot_status[wr_block] |=>
                       wr_refuse_q && !wr_grant_q)
      else $error("write to protected block not refused");

   // Commands while busy are dropped.
   chk_busy_drop: // [R9]
      assert property (cmd_req && !trk_ready |=>
                       cmd_drop_q && !cmd_accept_q)
      else $error("command accepted while busy");

   // A sealed flash blocks outside reads and commands.
   chk_sealed_flash: // [R10]
      assert property (all_locked && cmd_req |=>
                       ext_rd_block_q && !cmd_accept_q)
      else $error("sealed flash not enforced");

   // Reserved bits 31:8, 3 and 1 of the status word read zero.
   chk_reserved_zero: // [R11]
      assert property (rd_load && hit_fcs |=>
                       avm_readdata_q[31:8] == 24'h000000 &&
                       !avm_readdata_q[3] && !avm_readdata_q[1])
      else $error("reserved bits not zero");

   // Waitrequest is low for exactly one cycle per request.
   chk_one_wait: // [R11]
      assert property ((avm.read || avm.write) && avm_waitrequest_q
                       |=> !avm_waitrequest_q ##1 avm_waitrequest_q)
      else $error("waitrequest pulse malformed");

   // Interrupt follows unmasked status one cycle later.
   chk_irq_level:
      assert property (irq_q == $past(|(stat_q & mask_q)))
      else $error("interrupt output mismatch");

   // Writes to open blocks are granted, never refused.
   chk_write_granted: // [R7]
      assert property (wr_req && !prot_status[wr_block] |=>
                       wr_grant_q && !wr_refuse_q)
      else $error("write to open block not granted");

   // A ready, unsealed flash passes each command.
   chk_ready_accept: // [R9]
      assert property (cmd_req && trk_ready && !all_locked |=>
                       cmd_accept_q && !cmd_drop_q)
      else $error("command dropped while ready");

   // The ready port trails the tracker by one cycle.
   chk_ready_port: // [R1] [R2]
      assert property (!$past(sys_rst) |-> ready_q == $past(trk_ready))
      else $error("ready port wrong");

   // The outside read flag trails the sealed state by one cycle.
   chk_seal_flag: // [R10]
      assert property (!$past(sys_rst) |->
                       ext_rd_block_q == $past(all_locked))
      else $error("outside read flag wrong");

   // Unmapped places read as zero.
   chk_unmapped_zero: // [R11]
      assert property (rd_load && !(hit_fcs || hit_stat || hit_mask)
                       |=> avm_readdata_q == 32'h0000_0000)
      else $error("unmapped read not zero");

   // An event keeps its status bit even against a clear.
   chk_event_sticky:
      assert property (|evt_set |=> &(stat_q | ~$past(evt_set)))
      else $error("interrupt event lost");

   // Main scenarios worth seeing in a run.
   cov_status_read:
      cover property (rd_load && hit_fcs ##1 !avm_waitrequest_q);

   cov_write_refused:
      cover property (wr_refuse_q ##1 irq_q);

   cov_sealed_cmd:
      cover property (cmd_req && all_locked);

   cov_cmd_dropped:
      cover property (cmd_drop_q ##1 stat_q[IRQ_DROP]);

endmodule // flash_status_register

// ===== include/flash_status_pkg.sv
// Purpose: Shared constants and types for the flash status register block.
// Assumes: One 40 MHz system clock and a synchronous active-high reset.
// Notes:   Offsets are byte addresses on the Avalon-MM register bus.
package flash_status_pkg;

   // Register byte addresses.
   localparam logic [31:0] FCS_OFS      = 32'hFFFF_E520;
   localparam logic [31:0] IRQ_STAT_OFS = 32'hFFFF_E524;
   localparam logic [31:0] IRQ_MASK_OFS = 32'hFFFF_E528;

   // Field positions of the flash control and status word.
   localparam int RDY_BIT  = 0;
   localparam int ROM_BIT  = 2;
   localparam int PROT_LSB = 4;
   localparam int PROT_W   = 4;

   // Value that marks every block as protected.
   localparam logic [3:0] PROT_ALL = 4'hF;

   // Values after reset.
   localparam logic [31:0] FCS_RST  = 32'h0000_0001;
   localparam logic [3:0]  IRQ_RST  = 4'h0;
   localparam logic [1:0]  STRAP_RST = 2'h0;

   // Cycles after reset release before the strap is frozen.
   localparam logic [1:0]  STRAP_WAIT = 2'h3;

   // Interrupt status bit positions.
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FAIL = 1;
   localparam int IRQ_WREF = 2;
   localparam int IRQ_DROP = 3;
   localparam int IRQ_W    = 4;

   // Ready, busy and stuck-after-failure states.
   typedef enum logic [1:0] {
      ST_READY  = 2'b00,
      ST_BUSY   = 2'b01,
      ST_FAILED = 2'b10
   } op_state_e;

   // One Avalon-MM request from the bus master.
   typedef struct packed {
      logic        read;
      logic        write;
      logic [31:0] address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } avm_req_s;

   // Progress pulses from the command sequencer.
   typedef struct packed {
      logic start;
      logic done;
      logic fail;
      logic reset_cmd;
   } op_evt_s;

endpackage

// ===== hw/flash_op_tracker.sv
// Purpose: Tracks the automatic operation and drives the ready flag.
// Assumes: Sequencer pulses are one cycle wide and on clk_sys.
// Notes:   A failed operation sticks until reset or the reset command.
`timescale 1ns/100ps
module flash_op_tracker (
   input  wire logic                       clk_sys,
   input  wire logic                       sys_rst,
   input  wire flash_status_pkg::op_evt_s  evt,
   output logic                            ready_q
);
   import flash_status_pkg::*;

   op_state_e state_q;  // Current operation state.
   op_state_e state_d;  // Next operation state.

   ////////////////////////////////////////////////////////////////////
   // Next state: failure outranks completion in the same cycle.
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_READY: begin
            if (evt.start) begin
               state_d = ST_BUSY;             // [R1]
            end
         end
         ST_BUSY: begin
            if (evt.fail) begin
               state_d = ST_FAILED;           // [R3]
            end else if (evt.done) begin
               state_d = ST_READY;            // [R2]
            end
         end
         ST_FAILED: begin
            if (evt.reset_cmd) begin
               state_d = ST_READY;            // [R9]
            end
         end
         default: begin
            state_d = ST_READY;
         end
      endcase
   end

   // State and ready flag; reset always returns to ready.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_q <= ST_READY;                 // [R4]
         ready_q <= 1'b1;                     // [R4]
      end else begin
         state_q <= state_d;
         ready_q <= (state_d == ST_READY);    // [R1] [R2]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks on the ready flag.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   chk_busy_on_start: // [R1]
      assert property (ready_q && evt.start |=> !ready_q)
      else $error("ready flag did not drop on start");
   chk_ready_on_done: // [R2]
      assert property (!ready_q && state_q == ST_BUSY && evt.done
                       && !evt.fail |=> ready_q)
      else $error("ready flag did not return on done");
   chk_fail_sticks: // [R3]
      assert property (state_q == ST_BUSY && evt.fail
                       ##1 !evt.reset_cmd [*3] |-> !ready_q)
      else $error("ready flag left busy after failure");
   chk_reset_ready: // [R4]
      assert property (@(posedge clk_sys) disable iff (1'b0)
                       sys_rst |=> ready_q)
      else $error("reset did not restore ready flag");
   cov_fail_seen:
      cover property (state_q == ST_FAILED ##1 evt.reset_cmd);

endmodule // flash_op_tracker

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the flash status register block.
// Assumes: 40 MHz clk_sys, synchronous active-high sys_rst, Avalon-MM bus.
// Notes:   After time zero, every input but the clock is driven by non-blocking assignment at rising edges.
`timescale 1ns/100ps
module testbench;
   import flash_status_pkg::*;

   logic        clk_sys;        // System clock, 25 ns period.
   logic        sys_rst;        // Synchronous reset, active high.
   avm_req_s    avm;            // Bus request towards the block.
   logic [31:0] avm_readdata_q; // Read data from the block.
   logic        avm_waitrequest_q; // Bus answer, low for one cycle.
   op_evt_s     op_evt;         // Sequencer event pulses.
   logic        rom_mask_strap; // ROM kind pin, 1 means mask ROM.
   logic [3:0]  prot_status;    // Block protection levels.
   logic        wr_req;         // Data write request pulse.
   logic [1:0]  wr_block;       // Block index of the write request.
   logic        cmd_req;        // Command write request pulse.
   logic        wr_grant_q;     // Write allowed pulse.
   logic        wr_refuse_q;    // Write refused pulse.
   logic        cmd_accept_q;   // Command passed pulse.
   logic        cmd_drop_q;     // Command dropped pulse.
   logic        ext_rd_block_q; // Outside reads are blocked.
   logic        ready_q;        // Copy of the ready flag.
   logic        irq_q;          // Level interrupt.
   int          fail_count;     // Mismatches seen so far.
   int          compares;       // Comparisons made so far.
   int          cycles;         // Clock cycles since time zero.
   logic [31:0] rdat;           // Scratch read data.

   ////////////////////////////////////////////////////////////////////////
   // Clock, initial values and the design under test.
   initial begin
      clk_sys = 1'b0;
      sys_rst = 1'b1;
      avm = '0;
      op_evt = '0;
      rom_mask_strap = 1'b0;
      prot_status = 4'h0;
      wr_req = 1'b0;
      wr_block = 2'h0;
      cmd_req = 1'b0;
      fail_count = 0;
      compares = 0;
      cycles = 0;
   end

   // The clock toggles every half period.
   always #12.5 clk_sys = ~clk_sys;

   flash_status_register uut (
      .clk_sys           (clk_sys),
      .sys_rst           (sys_rst),
      .avm               (avm),
      .avm_readdata_q    (avm_readdata_q),
      .avm_waitrequest_q (avm_waitrequest_q),
      .op_evt            (op_evt),
      .rom_mask_strap    (rom_mask_strap),
      .prot_status       (prot_status),
      .wr_req            (wr_req),
      .wr_block          (wr_block),
      .cmd_req           (cmd_req),
      .wr_grant_q        (wr_grant_q),
      .wr_refuse_q       (wr_refuse_q),
      .cmd_accept_q      (cmd_accept_q),
      .cmd_drop_q        (cmd_drop_q),
      .ext_rd_block_q    (ext_rd_block_q),
      .ready_q           (ready_q),
      .irq_q             (irq_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Shared tasks.
   // Verdict and end of the run; the only place where the run stops.
   task automatic end_of_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Compares a seen value with the expected one and reports a mismatch.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s seen %h expected %h",
                  $time, msg, seen, exp);
      end
   endtask

   // One Avalon transfer; the request stands until waitrequest is low.
   task automatic bus(input logic rd, input logic [31:0] addr,
                      input logic [31:0] wd, output logic [31:0] rd_q);
      int n;
      n = 0;
      @(posedge clk_sys);
      avm <= '{read: rd, write: ~rd, address: addr, writedata: wd,
               byteenable: 4'hF};
      do begin
         @(posedge clk_sys);
         n++;
      end while (avm_waitrequest_q !== 1'b0);
      rd_q = avm_readdata_q;
      avm.read <= 1'b0;
      avm.write <= 1'b0;
      check(n, 32'h2, "bus answer delay");
   endtask

   // Reads a register and compares it.
   task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp,
                         input string msg);
      bus(1'b1, addr, 32'h0, rdat);
      check(rdat, exp, msg);
   endtask

   // Applies reset for four cycles with the given strap level.
   task automatic do_reset(input logic strap);
      @(posedge clk_sys);
      rom_mask_strap <= strap;
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk_sys);
   endtask

   // Sends one sequencer event pulse.
   task automatic evt(input op_evt_s v);
      @(posedge clk_sys);
      op_evt <= v;
      @(posedge clk_sys);
      op_evt <= '0;
      repeat (2) @(posedge clk_sys);
   endtask

   // Offers one command and checks whether it is accepted or dropped.
   task automatic cmd_try(input logic acc, input string msg);
      @(posedge clk_sys);
      cmd_req <= 1'b1;
      @(posedge clk_sys);
      cmd_req <= 1'b0;
      @(negedge clk_sys);
      check({cmd_accept_q, cmd_drop_q}, {acc, ~acc}, msg);
   endtask

   // Offers one data write and checks grant against refusal.
   task automatic wr_try(input logic [1:0] blk, input logic refuse);
      @(posedge clk_sys);
      wr_req <= 1'b1;
      wr_block <= blk;
      @(posedge clk_sys);
      wr_req <= 1'b0;
      @(negedge clk_sys);
      check({wr_grant_q, wr_refuse_q}, {~refuse, refuse}, "write");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios.
   // Reset values, ignored writes and an unmapped place.
   task automatic t_reset_regs();
      rd_chk(FCS_OFS, 32'h0000_0001, "status after reset");
      check(ready_q, 1'b1, "ready port after reset");
      rd_chk(IRQ_MASK_OFS, 32'h0, "mask after reset");
      bus(1'b0, FCS_OFS, 32'hFFFF_FFFE, rdat);
      rd_chk(FCS_OFS, 32'h0000_0001, "status after write");
      rd_chk(32'hFFFF_E530, 32'h0, "unmapped read");
      $display("test reset_regs done");
   endtask

   // Busy while running, ready after normal completion.
   task automatic t_busy_done();
      evt('{start: 1'b1, default: 1'b0});
      rd_chk(FCS_OFS, 32'h0000_0000, "busy readback");
      check(ready_q, 1'b0, "ready port busy");
      cmd_try(1'b0, "command while busy");
      evt('{done: 1'b1, default: 1'b0});
      rd_chk(FCS_OFS, 32'h0000_0001, "ready after done");
      check(ready_q, 1'b1, "ready port after done");
      cmd_try(1'b1, "command while ready");
      $display("test busy_done done");
   endtask

   // A failure sticks; reset command and hardware reset recover.
   task automatic t_fail_stuck();
      evt('{start: 1'b1, default: 1'b0});
      evt('{fail: 1'b1, done: 1'b1, default: 1'b0});
      evt('{done: 1'b1, default: 1'b0});
      repeat (40) @(posedge clk_sys);
      rd_chk(FCS_OFS, 32'h0000_0000, "stuck after fail");
      cmd_try(1'b0, "command while failed");
      evt('{reset_cmd: 1'b1, default: 1'b0});
      rd_chk(FCS_OFS, 32'h0000_0001, "reset command recovers");
      evt('{start: 1'b1, default: 1'b0});
      evt('{fail: 1'b1, default: 1'b0});
      do_reset(1'b0);
      rd_chk(FCS_OFS, 32'h0000_0001, "hardware reset recovers");
      $display("test fail_stuck done");
   endtask

   // ROM kind bit follows the strap captured after reset.
   task automatic t_rom_kind();
      do_reset(1'b1);
      rd_chk(FCS_OFS, 32'h0000_0005, "mask ROM kind");
      do_reset(1'b0);
      rd_chk(FCS_OFS, 32'h0000_0001, "flash kind");
      $display("test rom_kind done");
   endtask

   // Protection patterns show in bits 7:4 and gate data writes.
   task automatic t_protect();
      logic [3:0] pats [5];
      pats = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h6};
      foreach (pats[i]) begin
         @(posedge clk_sys);
         prot_status <= pats[i];
         rd_chk(FCS_OFS, {24'h0, pats[i], 4'h1}, "protect bits");
         for (int b = 0; b < 4; b++) begin
            wr_try(b[1:0], pats[i][b]);
         end
      end
      $display("test protect done");
   endtask

   // All blocks protected: outside reads flagged, commands dropped.
   task automatic t_seal();
      @(posedge clk_sys);
      prot_status <= PROT_ALL;
      repeat (3) @(posedge clk_sys);
      check(ext_rd_block_q, 1'b1, "outside read block");
      rd_chk(FCS_OFS, 32'h0000_00F1, "sealed status");
      cmd_try(1'b0, "command when sealed");
      @(posedge clk_sys);
      prot_status <= 4'h7;
      repeat (3) @(posedge clk_sys);
      check(ext_rd_block_q, 1'b0, "outside read open");
      cmd_try(1'b1, "command when unsealed");
      @(posedge clk_sys);
      prot_status <= 4'h0;
      $display("test seal done");
   endtask

   // Interrupt raised by a failure, masked, then cleared.
   task automatic t_irq();
      rd_chk(IRQ_STAT_OFS, 32'hC, "refuse and drop status");
      bus(1'b0, IRQ_STAT_OFS, 32'hF, rdat);
      rd_chk(IRQ_STAT_OFS, 32'h0, "status cleared");
      bus(1'b0, IRQ_MASK_OFS, 32'h2, rdat);
      evt('{start: 1'b1, default: 1'b0});
      evt('{fail: 1'b1, default: 1'b0});
      rd_chk(IRQ_STAT_OFS, 32'h2, "fail status");
      check(irq_q, 1'b1, "irq raised");
      bus(1'b0, IRQ_MASK_OFS, 32'h0, rdat);
      repeat (3) @(posedge clk_sys);
      check(irq_q, 1'b0, "irq masked");
      bus(1'b0, IRQ_MASK_OFS, 32'h2, rdat);
      bus(1'b0, IRQ_STAT_OFS, 32'h2, rdat);
      repeat (3) @(posedge clk_sys);
      check(irq_q, 1'b0, "irq cleared");
      evt('{reset_cmd: 1'b1, default: 1'b0});
      rd_chk(FCS_OFS, 32'h0000_0001, "ready after recovery");
      $display("test irq done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence and the hang guard.
   initial begin
      do_reset(1'b0);
      t_reset_regs();
      t_busy_done();
      t_fail_stuck();
      t_rom_kind();
      t_protect();
      t_seal();
      t_irq();
      end_of_test();
   end

   // Cuts a hang short well beyond the few hundred cycles of the run.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         end_of_test();
      end
   end

endmodule // testbench
